// ==== port_mux_defs.svh ====
// Register offsets, reset values and fixed field positions of the port pin function block
`ifndef PORT_MUX_DEFS_SVH
`define PORT_MUX_DEFS_SVH

// Address groups, taken from reg_addr[7:3]; reg_addr[2:0] selects the port
`define GRP_LATCH      5'h00
`define GRP_DIR        5'h01
`define GRP_CTRL       5'h02
`define GRP_MISC       5'h03

// Registers inside the misc group, selected by reg_addr[2:0]
`define MISC_PULLUP    3'h0
`define MISC_MEMMODE   3'h1
`define MISC_RISE      3'h2
`define MISC_FALL      3'h3
`define MISC_STATUS    3'h4
`define MISC_MASK      3'h5
`define MISC_CAPSEL    3'h6

// Field positions
`define MM_PORT4_IN    0
`define MM_EXPAND      1
`define STAT_P4_FALL   7
`define P0_IN_ONLY     8'h81
`define P6_OD_BITS     8'h0f

// Port numbers with special treatment
`define PORT0          3'd0
`define PORT1          3'd1
`define PORT4          3'd4
`define PORT5          3'd5
`define PORT6          3'd6
`define LAST_PORT      3'd6

// Reset values
`define RST_DIR        8'hff
`define RST_LATCH      8'h00
`define RST_CTRL       8'h00
`define RST_MEMMODE    2'h1

`endif

// ==== port_mux_pkg.sv ====
// Types shared by the port pin function block
package port_mux_pkg;

	typedef logic [6:0][7:0] port_bus_t;

	typedef struct packed {
		port_bus_t  latch;
		port_bus_t  dir;
		port_bus_t  ctrl;
		logic [6:0] pu_opt;
		logic       mm_in;
		logic       mm_exp;
		logic [6:0] rise;
		logic [6:0] fall;
		logic [7:0] status;
		logic [7:0] mask;
		logic       cap_sel;
		logic [7:0] rdata;
		port_bus_t  pout;
		port_bus_t  poe_n;
		port_bus_t  ppu;
		port_bus_t  level;
		logic       irq;
		logic [6:0] int_pulse;
		logic       cap_trig;
		logic       cnt_clk;
	} pm_state_t;

endpackage

// ==== sync2.sv ====
// Two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// First stage is read only by the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// ==== edge_detect.sv ====
// Per-bit edge detector with separate rising and falling enables
`timescale 1ns/1ps
module edge_detect #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Synchronised levels and edge selection
	input  wire logic [W-1:0] level,
	input  wire logic [W-1:0] rise_en,
	input  wire logic [W-1:0] fall_en,
	// One-cycle edge pulses
	output logic      [W-1:0] pulse
);
	logic [W-1:0] prev;
	logic         armed;

	// The first cycle only loads prev, so a pin high at reset is no edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev  <= '0;
			armed <= 1'b0;
		end else begin
			prev  <= level;
			armed <= 1'b1;
		end
	end

	assign pulse = {W{armed}} & ((rise_en & level & ~prev) | (fall_en & ~level & prev));
endmodule

// ==== port_pin_function_mux.sv ====
// Ports 0 to 6: direction, pull-ups, port/control mode selection and pin events
//
// Function
// - Port 0 bits 0 and 7 input only; bits 1 to 6 set by direction register.
// - Ports 1, 2, 3, 5, 6 choose direction per bit from own register.
// - Pull-up on input pins only when pull-up option asks; never on outputs.
// - Port mode or control mode chosen per pin on ports 0-3, 5, 6.
// - Seven external interrupt inputs detect rising, falling or both edges.
// - Valid edge on interrupt input 0 or 1 can trigger 16-bit timer capture.
// - Control mode: port 0 bit 0 gives timer count clock, bit 1 capture trigger.
// - Port 1 pin used as analog input has its pull-up forced off.
// - Port 4 direction set for all eight bits by memory expansion mode register.
// - Falling edge on any port 4 pin sets the falling edge test flag.
// - Expansion mode: port 4 is muxed low address/data, pull-ups off.
// - Expansion mode: port 5 drives high address byte, pull-ups off.
// - Expansion mode: port 6 carries external memory control signals.
// - Port 6 pins acting as memory control signals have pull-ups off.
// - Port 6 bits 0 to 3 are open-drain outputs without pull-up.
// - Port 6 pull-up option acts only on bits 4 to 7 configured as input.
// - Port 3 control mode routes timer clocks and outputs, clock and buzzer out.
`timescale 1ns/1ps
`include "port_mux_defs.svh"
module port_pin_function_mux (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   reset_n,
	// Register port
	input  wire logic [7:0]             reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [7:0]             reg_rdata,
	// Interrupt
	output logic                        irq,
	// Pins of ports 0 to 6
	input  wire port_mux_pkg::port_bus_t port_in,
	output port_mux_pkg::port_bus_t     port_out,
	output port_mux_pkg::port_bus_t     port_oe_n,
	output port_mux_pkg::port_bus_t     port_pullup,
	// Peripheral side of control mode
	input  wire port_mux_pkg::port_bus_t periph_out,
	input  wire port_mux_pkg::port_bus_t periph_drive,
	output port_mux_pkg::port_bus_t     pin_level,
	output logic      [6:0]             external_interrupt_inputs,
	output logic                        timer16_capture_trigger_in,
	output logic                        timer16_count_clock_in,
	// External memory bus side
	input  wire logic [7:0]             muxed_low_addr_data,
	input  wire logic                   muxed_low_addr_drive,
	input  wire logic [7:0]             high_address_out,
	input  wire logic                   mem_read_strobe_n,
	input  wire logic                   mem_write_strobe_n,
	input  wire logic                   address_latch_strobe
);
	import port_mux_pkg::*;

	pm_state_t st;
	pm_state_t next_st;
	logic      rst_n;
	port_bus_t lvl;
	port_bus_t dir_eff;
	logic [6:0] intp_edge;
	logic [7:0] p4_fall;
	logic [2:0] sel;
	logic       wr_ok;
	logic [7:0] stat_clr;
	logic [7:0] stat_set;

	// Reset released through two flip-flops, asserted at once
	sync2 #(.W(1)) u_rst_sync (
		.clk   (core_clk),
		.rst_n (reset_n),
		.d     (1'b1),
		.q     (rst_n)
	);

	// All pin levels cross into the clock domain before use
	sync2 #(.W(56)) u_pin_sync (
		.clk   (core_clk),
		.rst_n (rst_n),
		.d     (port_in),
		.q     (lvl)
	);

	// Interrupt inputs only see edges while their pin is in control mode
	edge_detect #(.W(7)) u_intp_edge (
		.clk     (core_clk),
		.rst_n   (rst_n),
		.level   (lvl[0][6:0]),
		.rise_en (st.rise & st.ctrl[0][6:0]),
		.fall_en (st.fall & st.ctrl[0][6:0]),
		.pulse   (intp_edge)
	);

	// Port 4 falling edges are watched in every mode
	edge_detect #(.W(8)) u_p4_edge (
		.clk     (core_clk),
		.rst_n   (rst_n),
		.level   (lvl[4]),
		.rise_en (8'h00),
		.fall_en (8'hff),
		.pulse   (p4_fall)
	);

	assign sel      = reg_addr[2:0];
	assign wr_ok    = reg_wr && (sel <= `LAST_PORT);
	assign stat_set = {|p4_fall, intp_edge};
	assign stat_clr = (reg_wr && reg_addr[7:3] == `GRP_MISC && sel == `MISC_STATUS) ? reg_wdata : 8'h00;

	// Effective direction, 1 meaning input
	always_comb begin
		dir_eff = st.dir;
		dir_eff[0] = st.dir[0] | `P0_IN_ONLY;
		dir_eff[4] = {8{st.mm_in}};
	end

	// Next state: register writes, reads, events and pin drive
	always_comb begin
		logic drv;
		logic val;
		logic pu;
		drv = 1'b0;
		val = 1'b0;
		pu = 1'b0;
		next_st = st;
		next_st.rdata = 8'h00;

		// Register writes
		if (wr_ok) begin
			unique case (reg_addr[7:3])
				`GRP_LATCH: begin
					next_st.latch[sel] = reg_wdata;
				end
				`GRP_DIR: begin
					// Port 4 has no per-bit direction; its direction lives in the mode register
					if (sel != `PORT4) begin
						next_st.dir[sel] = reg_wdata;
					end
				end
				`GRP_CTRL: begin
					if (sel != `PORT4) begin
						next_st.ctrl[sel] = reg_wdata;
					end
				end
				`GRP_MISC: begin
					unique case (sel)
						`MISC_PULLUP:  next_st.pu_opt = reg_wdata[6:0];
						`MISC_MEMMODE: begin
							next_st.mm_in  = reg_wdata[`MM_PORT4_IN];
							next_st.mm_exp = reg_wdata[`MM_EXPAND];
						end
						`MISC_RISE:    next_st.rise = reg_wdata[6:0];
						`MISC_FALL:    next_st.fall = reg_wdata[6:0];
						`MISC_MASK:    next_st.mask = reg_wdata;
						`MISC_CAPSEL:  next_st.cap_sel = reg_wdata[0];
						default: ;
					endcase
				end
				default: ;
			endcase
		end

		// Sticky status: a new event wins over a clear in the same cycle
		next_st.status = (st.status & ~stat_clr) | stat_set;

		// Register reads, answered in the next cycle
		if (reg_rd && sel <= `LAST_PORT) begin
			unique case (reg_addr[7:3])
				`GRP_LATCH: next_st.rdata = (lvl[sel] & dir_eff[sel]) | (st.latch[sel] & ~dir_eff[sel]);
				`GRP_DIR:   next_st.rdata = dir_eff[sel];
				`GRP_CTRL:  next_st.rdata = st.ctrl[sel];
				`GRP_MISC: begin
					unique case (sel)
						`MISC_PULLUP:  next_st.rdata = {1'b0, st.pu_opt};
						`MISC_MEMMODE: next_st.rdata = {6'h00, st.mm_exp, st.mm_in};
						`MISC_RISE:    next_st.rdata = {1'b0, st.rise};
						`MISC_FALL:    next_st.rdata = {1'b0, st.fall};
						`MISC_STATUS:  next_st.rdata = st.status;
						`MISC_MASK:    next_st.rdata = st.mask;
						`MISC_CAPSEL:  next_st.rdata = {7'h00, st.cap_sel};
						default:       next_st.rdata = 8'h00;
					endcase
				end
				default: next_st.rdata = 8'h00;
			endcase
		end

		// Pin drive, in rising priority: port mode, control mode, expansion, fixed pins
		for (int p = 0; p < 7; p++) begin
			for (int b = 0; b < 8; b++) begin
				drv = ~dir_eff[p][b];
				val = st.latch[p][b];
				pu = dir_eff[p][b] & st.pu_opt[p];
				if (st.ctrl[p][b]) begin
					if (p == 0 || p == 1) begin
						// Interrupt, timer and analog inputs never drive the pin
						drv = 1'b0;
						val = 1'b0;
						if (p == 1) begin
							pu = 1'b0;
						end
					end else begin
						drv = periph_drive[p][b];
						val = periph_out[p][b];
					end
				end
				if (st.mm_exp) begin
					if (p == 4) begin
						drv = muxed_low_addr_drive;
						val = muxed_low_addr_data[b];
						pu = 1'b0;
					end else if (p == 5) begin
						drv = 1'b1;
						val = high_address_out[b];
						pu = 1'b0;
					end else if (p == 6 && b >= 4) begin
						// Bit 6 is the wait input, the rest are strobes
						drv = (b != 6);
						val = (b == 4) ? mem_read_strobe_n :
						      (b == 5) ? mem_write_strobe_n : address_latch_strobe;
						pu = 1'b0;
					end
				end
				if (p == 6 && b < 4) begin
					// Open drain: only a low is driven, a high lets the pin float
					drv = drv & ~val;
					val = 1'b0;
					pu = 1'b0;
				end
				if (p == 0 && (b == 0 || b == 7)) begin
					drv = 1'b0;
				end
				next_st.pout[p][b] = val;
				next_st.poe_n[p][b] = ~drv;
				next_st.ppu[p][b] = pu & ~drv;
			end
		end

		// Peripheral side
		next_st.level = lvl;
		next_st.int_pulse = intp_edge;
		next_st.cap_trig = st.cap_sel ? intp_edge[0] : (intp_edge[1] & st.ctrl[0][1]);
		next_st.cnt_clk = st.ctrl[0][0] & lvl[0][0];
		next_st.irq = |(next_st.status & next_st.mask);
	end

	// Whole state in one register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.dir <= {7{`RST_DIR}};
			st.latch <= {7{`RST_LATCH}};
			st.ctrl <= {7{`RST_CTRL}};
			{st.mm_exp, st.mm_in} <= `RST_MEMMODE;
			st.poe_n <= {7{8'hff}};
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign reg_rdata = st.rdata;
	assign irq = st.irq;
	assign port_out = st.pout;
	assign port_oe_n = st.poe_n;
	assign port_pullup = st.ppu;
	assign pin_level = st.level;
	assign external_interrupt_inputs = st.int_pulse;
	assign timer16_capture_trigger_in = st.cap_trig;
	assign timer16_count_clock_in = st.cnt_clk;

	// Checks on the drive and event logic
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	p0_input_only_a: assert property (port_oe_n[0][0] && port_oe_n[0][7])
		else $error("port 0 bit 0 or 7 driven");

	p2_dir_drive_a: assert property ((st.ctrl[2] == 8'h00) |=> port_oe_n[2] == $past(st.dir[2]))
		else $error("port 2 drive does not follow direction");

	p2_latch_out_a: assert property ((st.ctrl[2] == 8'h00) |=> port_out[2] == $past(st.latch[2]))
		else $error("port 2 output does not follow latch");

	pullup_input_a: assert property ((port_pullup & ~port_oe_n) == '0)
		else $error("pull-up on a driven pin");

	analog_pullup_a: assert property (1'b1 |=> (port_pullup[1] & $past(st.ctrl[1])) == 8'h00)
		else $error("pull-up on analog input");

	p4_group_dir_a: assert property (!st.mm_exp |=> port_oe_n[4] == {8{$past(st.mm_in)}})
		else $error("port 4 direction not uniform");

	p4_fall_flag_a: assert property ((|p4_fall) |=> st.status[`STAT_P4_FALL] && (irq || !st.mask[`STAT_P4_FALL]))
		else $error("port 4 falling edge flag not set");

	exp_pullup_off_a: assert property (st.mm_exp |=> port_pullup[4] == 8'h00 && port_pullup[5] == 8'h00
			&& port_pullup[6][7:4] == 4'h0)
		else $error("pull-up active on expansion bus pin");

	exp_addr_hi_a: assert property (st.mm_exp |=> port_out[5] == $past(high_address_out) && port_oe_n[5] == 8'h00)
		else $error("high address not driven on port 5");

	exp_strobes_a: assert property (st.mm_exp |=> port_out[6][4] == $past(mem_read_strobe_n)
			&& port_out[6][5] == $past(mem_write_strobe_n) && port_oe_n[6][6])
		else $error("memory control pins wrong");

	open_drain_a: assert property (port_out[6][3:0] == 4'h0 && port_pullup[6][3:0] == 4'h0)
		else $error("port 6 low nibble not open drain");

	capture_edge_a: assert property ((!st.cap_sel && intp_edge[1] && st.ctrl[0][1]) |=> timer16_capture_trigger_in)
		else $error("capture trigger missing");

	intp_pulse_a: assert property (intp_edge[3] |=> external_interrupt_inputs[3] && st.status[3])
		else $error("interrupt edge not passed on");

	count_clock_a: assert property (!st.ctrl[0][0] |=> !timer16_count_clock_in)
		else $error("count clock outside control mode");

	irq_level_a: assert property (irq == |(st.status & st.mask))
		else $error("interrupt output disagrees with status");
endmodule

// ==== board_model.sv ====
// Board-side model of ports 0 to 6: device drive, external drivers and pull-ups
`timescale 1ns/1ps
module board_model
	import port_mux_pkg::*;
(
	// Clock
	input  wire logic      clk,
	// Device side of each pin
	input  wire port_bus_t dev_out,
	input  wire port_bus_t dev_oe_n,
	input  wire port_bus_t dev_pullup,
	// External drivers set by the bench
	input  wire port_bus_t ext_val,
	input  wire port_bus_t ext_en,
	// Resolved pin levels
	output port_bus_t      pin
);
	port_bus_t last;

	// Device drive wins; a released pin with no external driver and no pull-up shows the inverse of its last level,
	// so a stale value can never pass for a real one
	assign pin = (~dev_oe_n & dev_out) | (dev_oe_n & ext_en & ext_val)
		| (dev_oe_n & ~ext_en & (dev_pullup | ~last));

	// Remember the last resolved level
	always_ff @(posedge clk) begin
		last <= pin;
	end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the port pin function block
`timescale 1ns/1ps
module testbench;
	import port_mux_pkg::*;

	logic       core_clk = 0;
	logic       reset_n  = 0;
	logic [7:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0;
	logic       reg_wr = 0;
	logic       reg_rd = 0;
	logic [7:0] reg_rdata;
	logic       irq;
	port_bus_t  port_in, port_out, port_oe_n, port_pullup, pin_level;
	port_bus_t  periph_out = '0;
	port_bus_t  periph_drive = '0;
	port_bus_t  ext_val = '0;
	port_bus_t  ext_en = '1;
	logic [6:0] external_interrupt_inputs;
	logic       timer16_capture_trigger_in, timer16_count_clock_in;
	logic [7:0] muxed_low_addr_data = 0;
	logic       muxed_low_addr_drive = 0;
	logic [7:0] high_address_out = 0;
	logic       mem_read_strobe_n = 1;
	logic       mem_write_strobe_n = 1;
	logic       address_latch_strobe = 0;
	int         miscompares = 0;
	int         n_checks = 0;
	int         cap_cnt = 0;
	logic [6:0] int_seen = '0;

	port_pin_function_mux i_dut (
		.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.port_in(port_in), .port_out(port_out), .port_oe_n(port_oe_n), .port_pullup(port_pullup),
		.periph_out(periph_out), .periph_drive(periph_drive), .pin_level(pin_level),
		.external_interrupt_inputs(external_interrupt_inputs),
		.timer16_capture_trigger_in(timer16_capture_trigger_in),
		.timer16_count_clock_in(timer16_count_clock_in),
		.muxed_low_addr_data(muxed_low_addr_data), .muxed_low_addr_drive(muxed_low_addr_drive),
		.high_address_out(high_address_out), .mem_read_strobe_n(mem_read_strobe_n),
		.mem_write_strobe_n(mem_write_strobe_n), .address_latch_strobe(address_latch_strobe)
	);

	board_model i_board (
		.clk(core_clk), .dev_out(port_out), .dev_oe_n(port_oe_n), .dev_pullup(port_pullup),
		.ext_val(ext_val), .ext_en(ext_en), .pin(port_in)
	);

	// 50 MHz clock
	always #10 core_clk = ~core_clk;

	// Capture pulses last one cycle, so count them as they pass
	always @(posedge core_clk) begin
		if (timer16_capture_trigger_in === 1'b1)
			cap_cnt++;
		// Interrupt pulses are gathered per input; outputs are unknown before reset takes hold
		if (reset_n)
			int_seen <= int_seen | external_interrupt_inputs;
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		@(negedge core_clk);
		chk(reg_rdata, exp);
	endtask

	// Let pins and synchronised edges settle
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic end_of_test;
		if (miscompares == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Watchdog: the tests take well under 1000 cycles
	initial begin
		#100000;
		miscompares++;
		end_of_test;
	end

	initial begin
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		cyc(3);
		chk(port_oe_n, {56{1'b1}});
		chk(port_pullup, 0);
		rd(8'h09, 8'hff);
		rd(8'h19, 8'h01);
		// Direction and input-only bits of port 0
		wr(8'h08, 8'h00);
		rd(8'h08, 8'h81);
		cyc(2);
		chk(port_oe_n[0], 8'h81);
		// Port 2 upper nibble out, lower nibble in: latch for outputs, pin for inputs
		ext_val[2] <= 8'h03;
		wr(8'h02, 8'ha5);
		wr(8'h0a, 8'h0f);
		cyc(4);
		chk(port_oe_n[2], 8'h0f);
		chk(port_out[2][7:4], 4'ha);
		rd(8'h02, 8'ha3);
		chk(pin_level[2], 8'ha3);
		// Pull-ups on inputs only; analog pins on port 1 lose theirs
		wr(8'h18, 8'h7f);
		wr(8'h11, 8'h0f);
		wr(8'h0e, 8'hf0);
		wr(8'h06, 8'h05);
		cyc(2);
		chk(port_pullup[0], 8'h81);
		chk(port_pullup[1], 8'hf0);
		chk(port_pullup[2], 8'h0f);
		chk(port_pullup[6], 8'hf0);
		chk(port_oe_n[6][3:0], 4'h5);
		chk(port_out[6][3:0] & ~port_oe_n[6][3:0], 4'h0);
		// Edges: bit0 and bit2 rising, bit3 falling, bit4 both; capture from input 0
		wr(8'h10, 8'h7f);
		wr(8'h1a, 8'h15);
		wr(8'h1b, 8'h18);
		wr(8'h1d, 8'h7f);
		wr(8'h1e, 8'h01);
		ext_val[0] <= 8'h1d;
		cyc(7);
		rd(8'h1c, 8'h15);
		chk(irq, 1'b1);
		chk(cap_cnt, 1);
		chk(int_seen, 7'h15);
		chk(timer16_count_clock_in, 1'b1);
		wr(8'h1c, 8'hff);
		cyc(2);
		chk(irq, 1'b0);
		ext_val[0] <= 8'h00;
		cyc(7);
		rd(8'h1c, 8'h18);
		chk(cap_cnt, 1);
		chk(timer16_count_clock_in, 1'b0);
		chk(int_seen, 7'h1d);
		wr(8'h1c, 8'hff);
		// Capture taken from interrupt input 1 while its pin is in control mode
		wr(8'h1e, 8'h00);
		wr(8'h1a, 8'h02);
		ext_val[0] <= 8'h02;
		cyc(7);
		chk(cap_cnt, 2);
		chk(int_seen, 7'h1f);
		wr(8'h1c, 8'hff);
		// Port 4 falling edge sets the flag; masked, so no interrupt
		ext_val[4] <= 8'h20;
		cyc(7);
		ext_val[4] <= 8'h00;
		cyc(7);
		rd(8'h1c, 8'h80);
		chk(irq, 1'b0);
		wr(8'h1c, 8'hff);
		// Port 4 as output, whole byte
		wr(8'h04, 8'h96);
		wr(8'h19, 8'h00);
		cyc(2);
		chk(port_oe_n[4], 8'h00);
		chk(port_out[4], 8'h96);
		chk(port_pullup[4], 8'h00);
		// Port 3 control mode drives peripheral outputs
		periph_out[3]   <= 8'h3c;
		periph_drive[3] <= 8'hff;
		wr(8'h13, 8'hff);
		cyc(2);
		chk(port_out[3], 8'h3c);
		chk(port_oe_n[3], 8'h00);
		// External memory expansion
		muxed_low_addr_data  <= 8'h5a;
		muxed_low_addr_drive <= 1'b1;
		high_address_out     <= 8'hc3;
		mem_read_strobe_n    <= 1'b0;
		address_latch_strobe <= 1'b1;
		wr(8'h19, 8'h02);
		cyc(2);
		chk({port_out[4], port_oe_n[4], port_pullup[4]}, 24'h5a0000);
		chk({port_out[5], port_oe_n[5], port_pullup[5]}, 24'hc30000);
		chk({port_out[6][7], port_out[6][5:4], port_oe_n[6][7], port_oe_n[6][5:4]}, 6'h30);
		chk(port_pullup[6][7:4], 4'h0);
		// Unmapped places read zero
		rd(8'h07, 8'h00);
		rd(8'h28, 8'h00);
		end_of_test;
	end
endmodule
